/* rtl/eag_pkg.sv */
// Purpose: Shared types, constants and helpers of the Euler angle and gravity check core
// Assumes: Accelerations are signed with 1 g = ONE_G_DEF counts; angles are binary (2^16 = 360 deg)
// Notes:   CORDIC gain is removed with INV_K in Q15
package eag_pkg;
  localparam int ACC_W     = 16;
  localparam int ANG_W     = 16;
  localparam int CW        = 20;
  localparam int ITER_DEF  = 14;
  localparam int ONE_G_DEF = 4096;
  localparam int K_SHIFT   = 15;
  localparam logic [15:0]             INV_K     = 16'h4dba;
  localparam logic signed [ANG_W-1:0] ANG_ZERO  = 16'sh0000;
  localparam logic signed [ANG_W-1:0] ANG_HALF  = 16'sh8000;
  localparam logic signed [ANG_W-1:0] ANG_QUART = 16'sh4000;
  localparam logic signed [ANG_W-1:0] ANG_NQUART = 16'shc000;

  // Frame orientation choices: which unit axis is taken as the working frame
  typedef enum logic [1:0] {ORIENT_NATIVE, ORIENT_X_DOWN, ORIENT_Y_DOWN, ORIENT_FLIPPED} eag_orient_t;

  typedef struct packed {
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] y;
    logic signed [ACC_W-1:0] z;
  } eag_accel_t;

  typedef struct packed {
    logic signed [CW-1:0] x;
    logic signed [CW-1:0] y;
    logic signed [CW-1:0] z;
  } eag_gvec_t;

  typedef struct packed {
    logic signed [ANG_W-1:0] pitch;
    logic signed [ANG_W-1:0] roll;
    logic                    rollover;
    logic                    quality_err;
    logic [CW-1:0]           grav_err;
  } eag_result_t;

  // Arctangent of 2^-i in binary angle units
  function automatic logic [ANG_W-1:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = 16'h2000;
      4'h1: atan_lut = 16'h12e4;
      4'h2: atan_lut = 16'h09fb;
      4'h3: atan_lut = 16'h0511;
      4'h4: atan_lut = 16'h028b;
      4'h5: atan_lut = 16'h0146;
      4'h6: atan_lut = 16'h00a3;
      4'h7: atan_lut = 16'h0051;
      4'h8: atan_lut = 16'h0029;
      4'h9: atan_lut = 16'h0014;
      4'ha: atan_lut = 16'h000a;
      4'hb: atan_lut = 16'h0005;
      4'hc: atan_lut = 16'h0003;
      default: atan_lut = 16'h0001;
    endcase
  endfunction

  // Gravity is the negated measurement, then turned into the chosen frame
  function automatic eag_gvec_t grav_orient(input eag_accel_t a, input eag_orient_t o);
    eag_gvec_t g;
    eag_gvec_t r;
    g.x = -(CW'(a.x));
    g.y = -(CW'(a.y));
    g.z = -(CW'(a.z));
    case (o)
      ORIENT_X_DOWN:  r = '{x: -g.z, y: g.y, z: g.x};
      ORIENT_Y_DOWN:  r = '{x: g.x, y: -g.z, z: g.y};
      ORIENT_FLIPPED: r = '{x: -g.x, y: g.y, z: -g.z};
      default:        r = g;
    endcase
    return r;
  endfunction
endpackage

/* rtl/eag_angle_core.sv */
// Purpose: Euler pitch/roll, roll-over flag and gravity error check from one accelerometer sample
// Assumes: Samples and configuration come from logic on sys_clk_in; one sample in flight at a time
// Notes:   One iterative CORDIC serves roll, then pitch; fixed latency of 2*ITER+1 cycles
// Operation
// R1: Gravity is the negated measurement and pitch is atan2(-gx, sqrt(gy^2+gz^2)) held within +/-90 deg.
// R2: Roll is atan2(gy, gz) over the full +/-180 deg range.
// R3: Roll comes from one shared datapath usable for both rotation angle types.
// R4: The roll-over flag is set when the roll magnitude is strictly above 90 deg.
// R5: With gy and gz both zero roll may be anything, but the result still arrives on time.
// R6: No yaw is produced; only pitch and roll leave the block.
// R7: The gravity error is the absolute difference between 1 g and the gravity vector length.
// R8: The quality error is set only when the gravity error is strictly above the set maximum.
// R9: The configuring side sets the maximum error above expected external accelerations.
// R10: The working frame orientation is selectable so gimbal lock can be moved out of range.
// R11: Each accepted sample yields pitch, roll, flag and error together with one valid pulse.
// R12: Pitch and roll share one signed binary angle format of ANG_W bits.
module eag_angle_core import eag_pkg::*; #(
  parameter int ITER  = ITER_DEF,
  parameter int ONE_G = ONE_G_DEF
) (
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire eag_accel_t  sample_in,
  input  wire logic        sample_valid_in,
  input  wire eag_orient_t orient_in,
  input  wire logic [CW-1:0] max_err_in,
  output logic             sample_ready_out,
  output eag_result_t      result_out,
  output logic             result_valid_out
);
  localparam int IW      = $clog2(ITER + 1);
  localparam int LAT_CYC = 2 * ITER + 1;
  localparam int OBS_CYC = LAT_CYC + 1;  // Valid launched at edge LAT_CYC is sampled high one edge later
  localparam logic [IW-1:0] ITER_LAST = IW'(ITER - 1);
  localparam logic signed [CW-1:0] ONE_G_V = CW'(ONE_G);

  typedef enum logic [1:0] {ST_IDLE, ST_ROLL, ST_PITCH, ST_FINISH} eag_state_t;

  eag_state_t              state_r;
  logic [IW-1:0]           iter_r;
  logic signed [CW-1:0]    cx_r;
  logic signed [CW-1:0]    cy_r;
  logic [ANG_W-1:0]        cz_r;
  logic signed [ANG_W-1:0] roll_r;
  logic signed [ANG_W-1:0] pitch_r;
  logic [CW-1:0]           max_lat_r;
  logic signed [CW-1:0]    mag_r;
  eag_gvec_t               gvec_r;
  eag_gvec_t               g_in;
  logic signed [CW-1:0]    cx_nxt;
  logic signed [CW-1:0]    cy_nxt;
  logic [ANG_W-1:0]        cz_nxt;
  logic                    accept;
  logic                    last_iter;
  logic signed [CW-1:0]    err_abs;

  // Removes the CORDIC gain; the vector length is never negative
  function automatic logic signed [CW-1:0] gain_fix(input logic signed [CW-1:0] v);
    logic [CW+15:0] p;
    p = {16'h0000, v} * {{CW{1'b0}}, INV_K};
    return CW'(p >> K_SHIFT);
  endfunction

  assign g_in      = grav_orient(sample_in, orient_in);  // see R10
  assign accept    = (state_r == ST_IDLE) && sample_valid_in;
  assign last_iter = (iter_r == ITER_LAST);

  // One vectoring step drives y toward zero and accumulates the angle
  always_comb begin
    if (cy_r >= 0) begin
      cx_nxt = cx_r + (cy_r >>> iter_r);
      cy_nxt = cy_r - (cx_r >>> iter_r);
      cz_nxt = cz_r + atan_lut(4'(iter_r));
    end else begin
      cx_nxt = cx_r - (cy_r >>> iter_r);
      cy_nxt = cy_r + (cx_r >>> iter_r);
      cz_nxt = cz_r - atan_lut(4'(iter_r));
    end
  end

  // Sequencing: roll pass, pitch pass, then one cycle to publish
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:   if (accept) state_r <= ST_ROLL;
        ST_ROLL:   if (last_iter) state_r <= ST_PITCH;
        ST_PITCH:  if (last_iter) state_r <= ST_FINISH;
        ST_FINISH: state_r <= ST_IDLE;  // see R5
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // Iteration counter, restarted for each pass
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || state_r == ST_IDLE || state_r == ST_FINISH) begin
      iter_r <= '0;
    end else begin
      iter_r <= last_iter ? '0 : iter_r + 1'b1;
    end
  end

  // Shared CORDIC engine; roll first so its vector length feeds the pitch pass
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      cx_r      <= '0;
      cy_r      <= '0;
      cz_r      <= '0;
      gvec_r    <= '0;
      max_lat_r <= '0;
      roll_r    <= ANG_ZERO;
      pitch_r   <= ANG_ZERO;
      mag_r     <= '0;
    end else begin
      case (state_r)
        ST_IDLE: if (accept) begin
          gvec_r    <= g_in;
          max_lat_r <= max_err_in;  // Latched so a config change mid-sample cannot split a result
          // Half-plane fold: a negative z leg starts at 180 deg for full roll range, see R2
          cx_r <= (g_in.z < 0) ? -g_in.z : g_in.z;
          cy_r <= (g_in.z < 0) ? -g_in.y : g_in.y;
          cz_r <= (g_in.z < 0) ? ANG_HALF : ANG_ZERO;
        end
        ST_ROLL: begin
          if (last_iter) begin
            roll_r <= cz_nxt;            // see R3
            cx_r   <= gain_fix(cx_nxt);  // sqrt(gy^2+gz^2), never negative, see R1
            cy_r   <= -gvec_r.x;
            cz_r   <= ANG_ZERO;
          end else begin
            cx_r <= cx_nxt;
            cy_r <= cy_nxt;
            cz_r <= cz_nxt;
          end
        end
        ST_PITCH: begin
          if (last_iter) begin
            pitch_r <= cz_nxt;
            mag_r   <= gain_fix(cx_nxt);  // Full gravity length, see R7
          end else begin
            cx_r <= cx_nxt;
            cy_r <= cy_nxt;
            cz_r <= cz_nxt;
          end
        end
        default: ;
      endcase
    end
  end

  assign err_abs = (mag_r > ONE_G_V) ? (mag_r - ONE_G_V) : (ONE_G_V - mag_r);  // see R7

  // Publish all results together with one valid pulse; no yaw output exists, see R6
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      result_out       <= '0;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= (state_r == ST_FINISH);  // see R11
      if (state_r == ST_FINISH) begin
        // CORDIC can overshoot by a few LSB near the poles, so pitch is clamped, see R1
        if (pitch_r > ANG_QUART) result_out.pitch <= ANG_QUART;
        else if (pitch_r < ANG_NQUART) result_out.pitch <= ANG_NQUART;
        else result_out.pitch <= pitch_r;
        result_out.roll        <= roll_r;                                         // see R12
        result_out.rollover    <= (roll_r > ANG_QUART) || (roll_r < ANG_NQUART);  // see R4
        result_out.grav_err    <= err_abs;
        result_out.quality_err <= (err_abs > max_lat_r);                          // see R8
      end
    end
  end

  // Ready only while idle; drops on the accepting edge
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      sample_ready_out <= 1'b0;
    end else begin
      sample_ready_out <= (state_r == ST_IDLE) ? !sample_valid_in : (state_r == ST_FINISH);  // see R11
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_accept;
    (state_r == ST_IDLE) && sample_valid_in;
  endsequence

  sequence s_done;
    result_valid_out;
  endsequence

  // Properties see registered outputs one edge after launch, hence OBS_CYC rather than LAT_CYC
  a_result_latency: assert property (s_accept |-> ##[OBS_CYC:OBS_CYC] s_done)  // see R5
    else $error("result not delivered after fixed latency");
  a_ready_return: assert property (s_done |-> sample_ready_out)  // see R11
    else $error("ready not back with the result");
  a_single_pulse: assert property (s_done |=> !result_valid_out)  // see R11
    else $error("result valid longer than one cycle");
  a_busy_ready: assert property (s_accept |=> !sample_ready_out [*8])  // see R11
    else $error("ready raised while busy");
  a_pitch_range: assert property (s_done |-> (result_out.pitch <= ANG_QUART) && (result_out.pitch >= ANG_NQUART))  // see R1
    else $error("pitch outside quarter turn");
  a_rollover_flag: assert property (s_done |-> result_out.rollover == ((result_out.roll > ANG_QUART) || (result_out.roll < ANG_NQUART)))  // see R4
    else $error("roll-over flag disagrees with roll");
  a_roll_inverted: assert property ((s_accept and (g_in.z < 0 && g_in.y == 0)) |-> ##[OBS_CYC:OBS_CYC] result_out.rollover)  // see R2
    else $error("upside-down sample not flagged");
  a_roll_upright: assert property ((s_accept and (g_in.z > 0 && g_in.y == 0)) |-> ##[OBS_CYC:OBS_CYC] !result_out.rollover)  // see R4
    else $error("level sample flagged as roll-over");
  a_grav_error: assert property (s_done |-> result_out.grav_err == $past(err_abs))  // see R7
    else $error("gravity error wrong");
  a_quality_err: assert property (s_done |-> result_out.quality_err == (result_out.grav_err > max_lat_r))  // see R8
    else $error("quality error disagrees with threshold");
  a_orient_map: assert property (s_accept |=> gvec_r == grav_orient($past(sample_in), $past(orient_in)))  // see R10
    else $error("orientation mapping not applied");
endmodule

/* test/eag_accel_src.sv */
// Purpose: Accelerometer sample source facing the angle core
// Assumes: Core takes a sample at an edge where ready was high
// Notes:   Released data lines show the inverse of the last sample
module eag_accel_src import eag_pkg::*; (
  input  wire logic sys_clk_in,
  input  wire logic ready_in,
  output eag_accel_t sample_out,
  output logic       valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    sample_out = '0;
  end
  // Offer after gap+1 idle edges and hold until an edge takes it
  task automatic offer(input eag_accel_t a, input int gap);
    logic r;
    repeat (gap + 1) @(posedge sys_clk_in);
    #1;
    valid_out = 1'b1;
    sample_out = a;
    do begin
      r = ready_in;
      @(posedge sys_clk_in);
    end while (r !== 1'b1);
    #1;
    valid_out = 1'b0;
    sample_out = ~a; // Stale data must not pass for a held sample
  endtask
endmodule

/* test/testbench.sv */
// Purpose: Self-checking bench for the Euler angle and gravity check core
// Assumes: Expected angles from real arithmetic, compared with tolerance
// Notes:   ITER is shortened, so the answer tolerance is wider
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  import eag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IT = 10;
  localparam int TOL = 48;
  localparam real GTOL = 24.0;
  localparam real K = 32768.0 / 3.14159265358979;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  eag_accel_t sample;
  logic valid, ready, result_valid;
  eag_orient_t orient = ORIENT_NATIVE;
  logic [CW-1:0] max_err = '0;
  eag_result_t res;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 32'h8356;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  eag_accel_src eag_accel_src_i (.sys_clk_in(sys_clk), .ready_in(ready), .sample_out(sample), .valid_out(valid));
  eag_angle_core #(.ITER(IT), .ONE_G(ONE_G_DEF)) eag_angle_core_i (
    .sys_clk_in(sys_clk), .resetn_in(resetn), .sample_in(sample), .sample_valid_in(valid),
    .orient_in(orient), .max_err_in(max_err), .sample_ready_out(ready),
    .result_out(res), .result_valid_out(result_valid));
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One sample through the core; configuration is scrambled after accept
  task automatic run(input eag_accel_t a, input eag_orient_t o, input logic [CW-1:0] m, input bit lock);
    real gx, gy, gz, t, p, r, ge, d;
    int t0, n;
    logic signed [15:0] dv;
    orient = o;
    max_err = m;
    eag_accel_src_i.offer(a, $unsigned($random(seed)) % 3);
    t0 = cyc;
    orient = eag_orient_t'($random(seed));
    max_err = CW'($unsigned($random(seed)) % 1024);
    n = 0;
    while (result_valid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(cyc - t0, 2 * IT + 1)
    `CHK(ready, 1'b1)
    gx = -$itor(a.x);
    gy = -$itor(a.y);
    gz = -$itor(a.z);
    // Frame turn worked out independently of the core
    case (o)
      ORIENT_X_DOWN: begin t = gx; gx = -gz; gz = t; end
      ORIENT_Y_DOWN: begin t = gy; gy = -gz; gz = t; end
      ORIENT_FLIPPED: begin gx = -gx; gz = -gz; end
      default: ;
    endcase
    p = $atan2(-gx, $sqrt(gy * gy + gz * gz)) * K;
    r = $atan2(gy, gz) * K;
    ge = $sqrt(gx * gx + gy * gy + gz * gz) - ONE_G_DEF;
    ge = (ge < 0.0) ? -ge : ge;
    dv = res.pitch - 16'($rtoi(p));
    `CHK(dv <= TOL && dv >= -TOL, 1'b1)
    if (!lock) begin
      dv = res.roll - 16'($rtoi(r));
      `CHK(dv <= TOL && dv >= -TOL, 1'b1)
      t = (r < 0.0) ? -r : r;
      if (t > 16384.0 + TOL || t < 16384.0 - TOL) `CHK(res.rollover, t > 16384.0)
    end
    d = $itor(res.grav_err) - ge;
    `CHK(d <= GTOL && d >= -GTOL, 1'b1)
    d = ge - $itor(m);
    if (d > GTOL || d < -GTOL) `CHK(res.quality_err, d > 0.0)
    @(posedge sys_clk);
    #1;
    `CHK(result_valid, 1'b0)
  endtask
  // Watchdog sized well past the expected run length
  initial begin
    #400000;
    errors++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(result_valid, 1'b0)
    `CHK(ready, 1'b0)
    resetn = 1'b1;
    @(posedge sys_clk);
    #1;
    run('{x: 16'sh0000, y: 16'sh0000, z: 16'shf000}, ORIENT_NATIVE, 20'h00010, 1'b0);
    run('{x: 16'sh0000, y: 16'sh0000, z: 16'sh1000}, ORIENT_NATIVE, 20'h00000, 1'b0);
    run('{x: 16'shf000, y: 16'sh0000, z: 16'sh0000}, ORIENT_NATIVE, 20'h00100, 1'b1);
    run('{x: 16'sh0000, y: 16'sh0000, z: 16'she000}, ORIENT_NATIVE, 20'h00100, 1'b0);
    // Every frame choice with a sample off all axes
    for (int i = 0; i < 4; i++) run('{x: 16'sh0500, y: 16'shf600, z: 16'shf400}, eag_orient_t'(i), 20'h00200, 1'b0);
    for (int i = 0; i < 60; i++) begin
      eag_accel_t a;
      a = '{x: 16'($random(seed) % 4096), y: 16'($random(seed) % 2048), z: 16'($random(seed) % 4096)};
      // Push the y leg to at least half a g: a short roll vector loses too many bits for the angle tolerance
      a.y = a.y + ((a.y < 0) ? -16'sh0800 : 16'sh0800);
      run(a, eag_orient_t'($random(seed)), CW'($unsigned($random(seed)) % 1024), 1'b0);
    end
    test_done();
  end
endmodule
